/* File: pkg/xbsel_map.svh */
// Purpose: offsets, reset levels and timing counts of the side-bus control
// Assumes: 100 MHz ref_clk, isa system clock arrives as a pin and is sampled
// Notes:   definitions only
`ifndef XBSEL_MAP_SVH
`define XBSEL_MAP_SVH

// ==========================================
// port decodes
`define XBSEL_RTC_INDEX_PORT 16'h0070
`define XBSEL_RTC_DATA_PORT 16'h0071

// ==========================================
// reset levels
`define XBSEL_SEL_IDLE 1'h1
`define XBSEL_STROBE_IDLE 1'h0

// ==========================================
// timing: strobe width in isa system clock periods
`define XBSEL_STROBE_SYSCLKS 2'h2
// number of sync stages on pin inputs
`define XBSEL_SYNC_STAGES 2

`endif

/* File: pkg/xbsel_pkg.sv */
// Purpose: types of the side-bus control block
// Assumes: nothing
// Notes:   strobe state machine
`default_nettype none
package xbsel_pkg;
   // ==========================================
   // strobe state machine, one-hot
   typedef enum logic [2:0] {
      XBSEL_STB_IDLE = 3'h1,
      XBSEL_STB_HIGH = 3'h2,
      XBSEL_STB_WAIT = 3'h4
   } xbsel_stb_state_t;
endpackage
`default_nettype wire

/* File: sim/xbsel_chk.sv */
// Purpose: port checks for xbsel_ctl
// Assumes: outputs follow pins three edges on
// Notes: bound below
`default_nettype none
module xbsel_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic io_rd_cmd_n,
   input wire logic io_wr_cmd_n,
   input wire logic [15:0] io_addr,
   input wire logic pci_master_cycle,
   input wire logic prog_range_a_hit,
   input wire logic dma_channel_ack_n,
   input wire logic dma_read_side,
   input wire logic kbc_cpu_reset_req_n,
   input wire logic internal_rtc_gpo_en,
   input wire logic side_bus_gpo_en,
   input wire logic prog_sel_a_n,
   input wire logic side_xcvr_dir_n,
   input wire logic clock_chip_index_strobe,
   input wire logic clock_chip_sel_n,
   input wire logic cpu_init_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // edges since reset, io command present
   logic [2:0] up_r;
   logic ok, io;
   assign ok = up_r == 3'h4;
   assign io = !(io_rd_cmd_n && io_wr_cmd_n);
   always_ff @(posedge ref_clk) begin
      if (rst) up_r <= 3'h0;
      else if (!ok) up_r <= up_r + 3'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // checks
   reset_idle_a: assert property (up_r == 3'h0 |->
      prog_sel_a_n && side_xcvr_dir_n && clock_chip_sel_n && !clock_chip_index_strobe)
      else $error("not idle after reset");
   init_req_a: assert property (ok |-> cpu_init_req == !$past(kbc_cpu_reset_req_n, 3))
      else $error("init req");
   sel_a_hit_a: assert property (ok |->
      prog_sel_a_n == !($past(pci_master_cycle, 3) && $past(prog_range_a_hit, 3) && $past(io, 3)))
      else $error("sel a");
   sel_opens_a: assert property (ok && !prog_sel_a_n && !$past(side_bus_gpo_en, 3) |->
      !side_xcvr_dir_n) else $error("sel dir");
   rtc_sel_a: assert property (ok && !$past(internal_rtc_gpo_en, 3) |->
      clock_chip_sel_n == !($past(io, 3) && $past(io_addr, 3) == 16'h0071))
      else $error("rtc sel");
   dma_dir_a: assert property (ok &&
      !$past(side_bus_gpo_en, 3) && $past(dma_read_side, 3) && !$past(dma_channel_ack_n, 3)
      |-> !side_xcvr_dir_n) else $error("dma dir");
   stb_cause_a: assert property ($rose(clock_chip_index_strobe) && ok &&
      !$past(internal_rtc_gpo_en, 3) && !$past(internal_rtc_gpo_en, 4) |->
      !$past(io_wr_cmd_n, 4) && $past(io_addr, 4) == 16'h0070) else $error("stb cause");
   stb_width_a: assert property ($rose(clock_chip_index_strobe) && ok &&
      !$past(internal_rtc_gpo_en, 3) |->
      clock_chip_index_strobe[*7] ##[1:14] !clock_chip_index_strobe) else $error("stb width");
endmodule // xbsel_chk
bind xbsel_ctl xbsel_chk u_chk (.ref_clk, .rst, .io_rd_cmd_n, .io_wr_cmd_n, .io_addr,
   .pci_master_cycle, .prog_range_a_hit, .dma_channel_ack_n, .dma_read_side,
   .kbc_cpu_reset_req_n, .internal_rtc_gpo_en, .side_bus_gpo_en, .prog_sel_a_n,
   .side_xcvr_dir_n, .clock_chip_index_strobe, .clock_chip_sel_n, .cpu_init_req);
`default_nettype wire

/* File: sim/xbsel_ctl_test.sv */
// Purpose: random and corner traffic for xbsel_ctl
// Assumes: isa system clock 80 ns, unrelated to ref_clk
// Notes: each step holds pins 10 cycles, then idles
`default_nettype none
module xbsel_ctl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'h0;
   logic isa_sysclk = 1'h0;
   logic rst = 1'h1;
   logic io_rd_cmd_n, io_wr_cmd_n, mem_rd_cmd_n, pci_master_cycle, prog_range_a_hit;
   logic prog_range_b_hit, bios_range_hit, apic_range_hit, side_decode_en, dma_channel_ack_n;
   logic dma_read_side, kbc_push, internal_rtc_gpo_en, gp_out_strobe_alt, gp_out_clock_sel_alt;
   logic side_bus_gpo_en, gp_out_dir_alt, kbc_cpu_reset_req_n, prog_sel_a_n, prog_sel_b_n;
   logic side_xcvr_oe_n, side_xcvr_dir_n, clock_chip_index_strobe, clock_chip_sel_n;
   logic cpu_init_req, side_to_sys, e, mem_wr_cmd_n;
   logic [15:0] io_addr;
   logic [31:0] seed, r;
   int num_errors, checks_done, strobes, exp_strobes;
   // ==========================================
   // clocks, design and far side
   always #5 ref_clk = ~ref_clk;
   always #40 isa_sysclk = ~isa_sysclk;
   xbsel_ctl DUT (.ref_clk, .rst, .isa_sysclk, .io_rd_cmd_n, .io_wr_cmd_n, .mem_rd_cmd_n,
      .mem_wr_cmd_n, .io_addr, .pci_master_cycle, .prog_range_a_hit, .prog_range_b_hit,
      .bios_range_hit, .apic_range_hit, .side_decode_en, .dma_channel_ack_n, .dma_read_side,
      .kbc_cpu_reset_req_n, .internal_rtc_gpo_en, .gp_out_strobe_alt, .gp_out_clock_sel_alt,
      .side_bus_gpo_en, .gp_out_dir_alt, .prog_sel_a_n, .prog_sel_b_n, .side_xcvr_oe_n,
      .side_xcvr_dir_n, .clock_chip_index_strobe, .clock_chip_sel_n, .cpu_init_req);
   xbsel_peer PEER (.ref_clk, .kbc_push, .clock_chip_index_strobe, .side_xcvr_dir_n,
      .kbc_cpu_reset_req_n, .side_to_sys, .strobes);
   // ==========================================
   // compare, close, drive one step, expected levels
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic apply(input logic [31:0] v);
      io_rd_cmd_n <= v[2:0] != 3'h1;
      io_wr_cmd_n <= v[2:0] != 3'h2;
      mem_rd_cmd_n <= v[2:0] != 3'h3;
      dma_channel_ack_n <= v[2:0] != 3'h4;
      mem_wr_cmd_n <= v[2:0] != 3'h5;
      {pci_master_cycle, prog_range_a_hit, prog_range_b_hit, bios_range_hit} <= v[6:3];
      {apic_range_hit, side_decode_en, dma_read_side, kbc_push} <= v[10:7];
      io_addr <= v[12] ? v[31:16] : {15'h0038, v[11]};
      internal_rtc_gpo_en <= v[13] && v[14] && v[2:0] != 3'h2;
      {gp_out_strobe_alt, gp_out_clock_sel_alt, gp_out_dir_alt} <= v[17:15];
      side_bus_gpo_en <= v[18] && v[19];
   endtask
   function automatic logic sel_hit(input logic hit);
      return !(pci_master_cycle && hit && !(io_rd_cmd_n && io_wr_cmd_n));
   endfunction
   function automatic logic dir_n();
      if (side_bus_gpo_en) return gp_out_dir_alt;
      return !(!io_rd_cmd_n || !sel_hit(prog_range_a_hit) || !sel_hit(prog_range_b_hit)
         || !dma_channel_ack_n && dma_read_side
         || !mem_rd_cmd_n && (bios_range_hit || apic_range_hit && pci_master_cycle));
   endfunction
   // ==========================================
   // corner steps first, then random ones
   initial begin
      seed = 32'hB2695E92;
      apply(32'h0);
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      for (int i = 0; i < 300; i++) begin
         r = i < 8 ? 32'h7F8 | i | (i == 2 ? 32'h0 : 32'h800) : $random(seed);
         @(posedge ref_clk);
         apply(r);
         repeat (9) @(posedge ref_clk);
         #1;
         check("sel_a", prog_sel_a_n, sel_hit(prog_range_a_hit));
         check("sel_b", prog_sel_b_n, sel_hit(prog_range_b_hit));
         check("dir", side_to_sys, !dir_n());
         check("init", cpu_init_req, kbc_push);
         e = !(io_addr == 16'h0071 && !(io_rd_cmd_n && io_wr_cmd_n));
         check("rtc_sel", clock_chip_sel_n, internal_rtc_gpo_en ? gp_out_clock_sel_alt : e);
         e = side_bus_gpo_en || sel_hit(prog_range_a_hit) && sel_hit(prog_range_b_hit)
            && !(side_decode_en && !(io_rd_cmd_n && io_wr_cmd_n && mem_rd_cmd_n && mem_wr_cmd_n));
         check("oe", side_xcvr_oe_n, e);
         e = internal_rtc_gpo_en ? gp_out_strobe_alt : !io_wr_cmd_n && io_addr == 16'h0070;
         check("stb", clock_chip_index_strobe, e);
         exp_strobes += e;
         @(posedge ref_clk);
         apply(32'h0);
         repeat (4) @(posedge ref_clk);
         for (int k = 0; k < 40 && clock_chip_index_strobe; k++) @(posedge ref_clk);
         if (clock_chip_index_strobe !== 1'h0) begin
            num_errors++;
            report_and_stop;
         end
         repeat (4) @(posedge ref_clk);
      end
      check("strobes", strobes, exp_strobes);
      report_and_stop;
   end
endmodule // xbsel_ctl_test
`default_nettype wire

/* File: sim/xbsel_peer.sv */
// Purpose: keyboard controller, transceiver and clock chip on the side bus
// Assumes: strobe pulses are clean levels
// Notes: reset request line has a pull-up
`default_nettype none
module xbsel_peer (
   input wire logic ref_clk,
   input wire logic kbc_push,
   input wire logic clock_chip_index_strobe,
   input wire logic side_xcvr_dir_n,
   output logic kbc_cpu_reset_req_n,
   output logic side_to_sys,
   output int strobes
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_r;
   // ==========================================
   // request sinks the pulled-up line; transceiver turns toward system
   assign kbc_cpu_reset_req_n = !kbc_push;
   assign side_to_sys = !side_xcvr_dir_n;
   // clock chip latches its index once per strobe rise
   always_ff @(posedge ref_clk) begin
      last_r <= clock_chip_index_strobe;
      if (clock_chip_index_strobe && !last_r) strobes <= strobes + 1;
   end
endmodule // xbsel_peer
`default_nettype wire

/* File: src/xbsel_ctl.sv */
// Purpose: side-bus chip selects, clock-chip strobe/select, cpu init and transceiver control
// Assumes: isa commands, acks and decodes arrive asynchronously and are synchronised here
// Notes:   all outputs registered; two cycles of sync latency on every pin input
//
// Summary of operation
// - programmable selects low for PCI-master I/O cycles hitting their range
// - an active programmable select enables transceiver output enable and direction
// - keyboard controller reset request becomes a processor INIT request
// - strobe starts at falling I/O write, ends at the second system clock rise
// - clock-chip select low on I/O read or write to port 71h
// - strobe and clock-chip select pins may become general purpose outputs
// - direction low on every I/O read cycle
// - memory cycles assert direction only for BIOS or APIC decode
// - PCI-master reads assert direction from falling read command
// - ISA-master memory reads assert direction only for BIOS decode
// - direction released at rising edge of the causing read command
// - DMA reads from side bus: direction low while channel ack low
// - otherwise direction held high, inactive
// - direction pin may become a general purpose output
// - output enable from falling command when decode enabled, or from an active programmable select
`include "xbsel_map.svh"
`default_nettype none
module xbsel_ctl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic isa_sysclk,
   input wire logic io_rd_cmd_n,
   input wire logic io_wr_cmd_n,
   input wire logic mem_rd_cmd_n,
   input wire logic mem_wr_cmd_n,
   input wire logic [15:0] io_addr,
   input wire logic pci_master_cycle,
   input wire logic prog_range_a_hit,
   input wire logic prog_range_b_hit,
   input wire logic bios_range_hit,
   input wire logic apic_range_hit,
   input wire logic side_decode_en,
   input wire logic dma_channel_ack_n,
   input wire logic dma_read_side,
   input wire logic kbc_cpu_reset_req_n,
   input wire logic internal_rtc_gpo_en,
   input wire logic gp_out_strobe_alt,
   input wire logic gp_out_clock_sel_alt,
   input wire logic side_bus_gpo_en,
   input wire logic gp_out_dir_alt,
   output logic prog_sel_a_n,
   output logic prog_sel_b_n,
   output logic side_xcvr_oe_n,
   output logic side_xcvr_dir_n,
   output logic clock_chip_index_strobe,
   output logic clock_chip_sel_n,
   output logic cpu_init_req
);
   localparam int NSYNC = 16;

   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_q;
   logic sysclk_s;
   logic iord_s;
   logic iowr_s;
   logic memrd_s;
   logic memwr_s;
   logic pci_s;
   logic hit_a_s;
   logic hit_b_s;
   logic bios_s;
   logic apic_s;
   logic dec_en_s;
   logic dack_s;
   logic dmard_s;
   logic kbc_cpu_reset_req_n_s;
   logic rtc_gpo_s;
   logic bus_gpo_s;
   logic [15:0] addr_r;
   logic [15:0] addr_meta_r;
   logic iowr_prev_r;
   logic sysclk_prev_r;
   logic [1:0] stb_cnt_r;
   logic [1:0] stb_cnt_nxt;
   xbsel_pkg::xbsel_stb_state_t stb_state_r;
   xbsel_pkg::xbsel_stb_state_t stb_state_nxt;
   logic stb_on;
   logic dir_read_on;
   logic sel_a_on;
   logic sel_b_on;
   logic oe_on;
   logic [1:0] hit_s;
   logic [1:0] sel_on;
   logic rtc_data_hit;
   logic [2:0] gpo_q;
   logic strobe_alt_s;
   logic clock_sel_alt_s;
   logic dir_alt_s;

   // ==========================================
   // decode helpers
   // an i/o cycle is under way while either i/o command is low
   function automatic logic io_cycle(input logic rd_n, input logic wr_n);
      return !rd_n || !wr_n;
   endfunction

   // one-cycle rise of a synchronised level, from its previous sample
   function automatic logic rise_seen(input logic prev, input logic now);
      return now && !prev;
   endfunction

   // ==========================================
   // synchronise pin inputs
   // commands and decodes share one bundle, so they stay aligned cycle for cycle
   // and a command never meets a decode from a different bus cycle
   assign raw_in = {isa_sysclk, io_rd_cmd_n, io_wr_cmd_n, mem_rd_cmd_n, mem_wr_cmd_n,
                    pci_master_cycle, prog_range_a_hit, prog_range_b_hit, bios_range_hit,
                    apic_range_hit, side_decode_en, dma_channel_ack_n, dma_read_side,
                    kbc_cpu_reset_req_n, internal_rtc_gpo_en, side_bus_gpo_en};

   xbsel_sync #(
      .WIDTH(NSYNC),
      .INIT(16'h7C14)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(raw_in),
      .q(sync_q)
   );

   assign {sysclk_s, iord_s, iowr_s, memrd_s, memwr_s, pci_s, hit_a_s, hit_b_s, bios_s,
           apic_s, dec_en_s, dack_s, dmard_s, kbc_cpu_reset_req_n_s, rtc_gpo_s, bus_gpo_s} = sync_q;

   // general purpose output values are pins as well; same latency as the enables
   xbsel_sync #(
      .WIDTH(3),
      .INIT(3'h0)
   ) u_gpo_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({gp_out_strobe_alt, gp_out_clock_sel_alt, gp_out_dir_alt}),
      .q(gpo_q)
   );

   assign {strobe_alt_s, clock_sel_alt_s, dir_alt_s} = gpo_q;

   // address held stable by the bus during a command; two stages anyway
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_meta_r <= 16'h0000;
         addr_r <= 16'h0000;
      end else begin
         addr_meta_r <= io_addr;
         addr_r <= addr_meta_r;
      end
   end

   // ==========================================
   // edge history of write command; idle high so reset makes no false fall
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         iowr_prev_r <= 1'h1;
      end else begin
         iowr_prev_r <= iowr_s;
      end
   end

   // edge history of system clock; low after reset like its sync stage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sysclk_prev_r <= 1'h0;
      end else begin
         sysclk_prev_r <= sysclk_s;
      end
   end

   // ==========================================
   // index strobe: start at falling write to port 70h, count two sysclk rises
   // the wait state holds off a second strobe until the command rises, so a
   // long write cannot make the clock chip latch its index twice
   always_comb begin
      stb_state_nxt = stb_state_r;
      stb_cnt_nxt = stb_cnt_r;
      case (stb_state_r)
         xbsel_pkg::XBSEL_STB_IDLE: begin
            if (rise_seen(!iowr_prev_r, !iowr_s) && addr_r == `XBSEL_RTC_INDEX_PORT) begin
               stb_state_nxt = xbsel_pkg::XBSEL_STB_HIGH;
               stb_cnt_nxt = 2'h0;
            end
         end
         xbsel_pkg::XBSEL_STB_HIGH: begin
            if (rise_seen(sysclk_prev_r, sysclk_s)) begin
               stb_cnt_nxt = stb_cnt_r + 2'h1;
               if (stb_cnt_r + 2'h1 == `XBSEL_STROBE_SYSCLKS) begin
                  stb_state_nxt = xbsel_pkg::XBSEL_STB_WAIT;
               end
            end
         end
         xbsel_pkg::XBSEL_STB_WAIT: begin
            if (iowr_s) begin // one strobe per write command
               stb_state_nxt = xbsel_pkg::XBSEL_STB_IDLE;
            end
         end
         default: begin
            stb_state_nxt = xbsel_pkg::XBSEL_STB_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stb_state_r <= xbsel_pkg::XBSEL_STB_IDLE;
         stb_cnt_r <= 2'h0;
      end else begin
         stb_state_r <= stb_state_nxt;
         stb_cnt_r <= stb_cnt_nxt;
      end
   end

   assign stb_on = (stb_state_r == xbsel_pkg::XBSEL_STB_HIGH);

   // ==========================================
   // decode terms
   // the two programmable selects share one decode, one copy per range
   assign hit_s = {hit_b_s, hit_a_s};
   genvar j;
   generate
      for (j = 0; j < 2; j = j + 1) begin : g_sel
         assign sel_on[j] = pci_s && hit_s[j] && io_cycle(iord_s, iowr_s);
      end
   endgenerate
   assign sel_a_on = sel_on[0];
   assign sel_b_on = sel_on[1];
   // read terms for direction; command rising ends them, channel ack rising ends the DMA term
   assign dir_read_on = !iord_s
      || (!memrd_s && (bios_s || (pci_s && apic_s)))
      || (dmard_s && !dack_s);
   assign oe_on = dec_en_s && (io_cycle(iord_s, iowr_s) || !memrd_s || !memwr_s);
   // clock-chip data port access, read or write
   assign rtc_data_hit = io_cycle(iord_s, iowr_s) && addr_r == `XBSEL_RTC_DATA_PORT;

   // ==========================================
   // programmable selects
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prog_sel_a_n <= `XBSEL_SEL_IDLE;
         prog_sel_b_n <= `XBSEL_SEL_IDLE;
      end else begin
         prog_sel_a_n <= !sel_a_on;
         prog_sel_b_n <= !sel_b_on;
      end
   end

   // ==========================================
   // transceiver output enable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         side_xcvr_oe_n <= `XBSEL_SEL_IDLE;
      end else if (bus_gpo_s) begin
         side_xcvr_oe_n <= `XBSEL_SEL_IDLE; // no side bus fitted
      end else begin
         side_xcvr_oe_n <= !(oe_on || sel_a_on || sel_b_on);
      end
   end

   // ==========================================
   // transceiver direction
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         side_xcvr_dir_n <= `XBSEL_SEL_IDLE;
      end else if (bus_gpo_s) begin
         side_xcvr_dir_n <= dir_alt_s;
      end else begin
         side_xcvr_dir_n <= !(dir_read_on || sel_a_on || sel_b_on);
      end
   end

   // ==========================================
   // clock-chip index strobe; the pin becomes a plain output when the clock is internal
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clock_chip_index_strobe <= `XBSEL_STROBE_IDLE;
      end else if (rtc_gpo_s) begin
         clock_chip_index_strobe <= strobe_alt_s;
      end else begin
         clock_chip_index_strobe <= stb_on;
      end
   end

   // clock-chip select on data port accesses, same fallback as the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clock_chip_sel_n <= `XBSEL_SEL_IDLE;
      end else if (rtc_gpo_s) begin
         clock_chip_sel_n <= clock_sel_alt_s;
      end else begin
         clock_chip_sel_n <= !rtc_data_hit;
      end
   end

   // ==========================================
   // processor init request
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cpu_init_req <= 1'h0;
      end else begin
         cpu_init_req <= !kbc_cpu_reset_req_n_s;
      end
   end
endmodule // xbsel_ctl
`default_nettype wire

/* File: src/xbsel_sync.sv */
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes:   first stage is read only by the second stage
`include "xbsel_map.svh"
`default_nettype none
module xbsel_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // ==========================================
   // two stages per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               meta_r[i] <= INIT[i];
               q[i] <= INIT[i];
            end else begin
               meta_r[i] <= d[i];
               q[i] <= meta_r[i];
            end
         end
      end
   endgenerate
endmodule // xbsel_sync
`default_nettype wire
